/* hw/ppac_pkg.sv */
// Purpose: constants for the page protection access controller
// Assumes: 50 MHz system clock
// Notes: times kept in their own unit, cycle counts derived
package ppac_pkg;
  localparam int PPAC_PAGES = 16;
  localparam int PPAC_PAGE_BITS = 256;
  localparam int PPAC_BLOCK_BITS = 32;
  localparam int PPAC_BLOCKS = 8;
  localparam int PPAC_SERIAL_BITS = 64;
  localparam int PPAC_CLK_MHZ = 50;
  localparam int PPAC_PROG_MS = 10;
  localparam int PPAC_AIP_US = 1100;
  localparam int PPAC_SCL_TO_MS = 25;
  localparam int PPAC_PROG_CYC = PPAC_PROG_MS * 1000 * PPAC_CLK_MHZ;
  localparam int PPAC_AIP_CYC = PPAC_AIP_US * PPAC_CLK_MHZ;
  localparam int PPAC_SCL_TO_CYC = PPAC_SCL_TO_MS * 1000 * PPAC_CLK_MHZ;
  localparam int PPAC_PROT_BITS = 4;
  localparam int PPAC_PROT_RD = 0;
  localparam int PPAC_PROT_WR = 1;
  localparam int PPAC_PROT_AND = 2;
  localparam int PPAC_PROT_AUTH = 3;
  localparam logic [3:0] PPAC_PROT_RESET = 4'h0;
  localparam logic [1:0] PPAC_ST_OK = 2'h0;
  localparam logic [1:0] PPAC_ST_RD_DENIED = 2'h1;
  localparam logic [1:0] PPAC_ST_MAC_FAIL = 2'h2;
  localparam logic [1:0] PPAC_ST_BUSY = 2'h3;
  typedef enum logic [1:0] {
    PPAC_CMD_READ,
    PPAC_CMD_WRITE,
    PPAC_CMD_PROT,
    PPAC_CMD_PAD
  } ppac_cmd_t;
endpackage

/* hw/ppac_core.sv */
// Purpose: per page access control for a 16 page user store
// Assumes: inputs synchronous to clk_sys; mac check done outside
// Notes: nonvolatile array modelled as flops
`timescale 1ns/1ps
`default_nettype none
// How it works
// RL1: sixteen pages of 256 bits, per-page settings
// RL2: each setting affects only its page
// RL3: all protection clear at delivery
// RL4: read-protected page refuses user reads
// RL5: hash port still sees protected data
// RL6: write-protected page never changes
// RL7: and-only mode stores old AND new
// RL8: write protection overrides and-only mode
// RL9: host supplies correct MAC for auth pages
// RL10: after MAC pass, other settings still apply
// RL11: auth pages need MAC for writes, settings
// RL12: 256-bit scratchpad for secret and challenge
// RL13: lsb first, least byte first
// RL14: rf programming starts after end of frame
// RL15: i2c programming starts after final ack
// RL16: access pulse only for pad, control writes
// RL17: long scl low acts as stop
// RL18: 64-bit serial id readable and hashed
// RL19: protection settings never clear
// RL20: programming ends within ten milliseconds
// RL21: access pulse lasts about 1.1 ms
// RL22: mac failure changes nothing, reports error
// RL23: no command taken while programming
module ppac_core
  import ppac_pkg::*;
#(
  parameter int PROG_CYC = PPAC_PROG_CYC,
  parameter int AIP_CYC = PPAC_AIP_CYC,
  parameter int SCL_TO_CYC = PPAC_SCL_TO_CYC,
  parameter logic [63:0] SERIAL_ID = 64'h0123456789ABCDEF
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire ppac_cmd_t cmd_op,
  input wire logic cmd_from_rf,
  input wire logic cmd_ctrl_write,
  input wire logic [3:0] cmd_page,
  input wire logic [2:0] cmd_block,
  input wire logic [31:0] cmd_wdata,
  input wire logic [3:0] cmd_prot,
  input wire logic cmd_mac_ok,
  input wire logic rf_eof,
  input wire logic i2c_last_ack,
  input wire logic scl_in,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [1:0] rsp_status,
  output logic [31:0] rsp_rdata,
  output logic [3:0] rsp_prot,
  output logic busy,
  output logic rf_access_pulse,
  output logic i2c_stop_forced,
  input wire logic [3:0] hash_page,
  output logic [255:0] hash_page_data,
  output logic [255:0] pad_data,
  output logic [63:0] device_serial_id
);
  typedef enum {
    PPAC_IDLE,
    PPAC_WAIT_START,
    PPAC_PROG
  } ppac_state_t;

  logic [31:0] mem_reg [PPAC_PAGES][PPAC_BLOCKS]; // RL1
  logic [3:0] prot_reg [PPAC_PAGES];
  logic [31:0] pad_reg [PPAC_BLOCKS]; // RL12
  ppac_state_t state_reg;
  logic [31:0] prog_cnt_reg;
  logic [31:0] aip_cnt_reg;
  logic [31:0] scl_cnt_reg;
  logic pend_is_prot_reg;
  logic pend_rf_reg;
  logic pend_aip_reg;
  logic [3:0] pend_page_reg;
  logic [2:0] pend_block_reg;
  logic [31:0] pend_data_reg;
  logic [3:0] pend_prot_reg;
  logic [1:0] rsp_status_reg;
  logic [31:0] rsp_rdata_reg;
  logic [3:0] rsp_prot_reg;
  logic rsp_valid_reg;

  wire [3:0] sel_prot = prot_reg[cmd_page]; // RL2
  wire rd_block = sel_prot[PPAC_PROT_RD]; // RL4
  wire wr_block = sel_prot[PPAC_PROT_WR];
  wire and_mode = sel_prot[PPAC_PROT_AND] & ~wr_block; // RL8
  wire need_mac = sel_prot[PPAC_PROT_AUTH]; // RL11
  wire mac_fail = need_mac & ~cmd_mac_ok; // RL9
  wire [31:0] old_word = mem_reg[cmd_page][cmd_block];
  wire [31:0] new_word = and_mode ? (old_word & cmd_wdata) : cmd_wdata; // RL7
  wire idle = (state_reg == PPAC_IDLE);
  wire take = cmd_valid & idle; // RL23
  wire is_wr = take & (cmd_op == PPAC_CMD_WRITE);
  wire is_pr = take & (cmd_op == PPAC_CMD_PROT);
  wire is_pad = take & (cmd_op == PPAC_CMD_PAD);
  wire is_rd = take & (cmd_op == PPAC_CMD_READ);
  // refused writes still answer, but skip programming
  wire wr_go = is_wr & ~mac_fail & ~wr_block; // RL6 RL10 RL22
  wire pr_go = is_pr & ~mac_fail; // RL22
  wire prog_start = pend_rf_reg ? rf_eof : i2c_last_ack; // RL14 RL15
  wire prog_done = (prog_cnt_reg == 32'(PROG_CYC - 1)); // RL20
  wire aip_go = is_pad | (take & cmd_ctrl_write); // RL16
  logic [1:0] status_next;
  wire scl_at_limit = (scl_cnt_reg == 32'(SCL_TO_CYC));
  // all page settings side by side, so stickiness can be checked at once
  logic [63:0] prot_flat;

  always_comb begin
    prot_flat = 64'h0;
    for (int p = 0; p < PPAC_PAGES; p++) begin
      prot_flat[p*4 +: 4] = prot_reg[p];
    end
  end

  // only reads and refused requests pick a non-ok status
  always_comb begin
    status_next = PPAC_ST_OK;
    if (is_rd && rd_block) begin
      status_next = PPAC_ST_RD_DENIED;
    end else if ((is_wr || is_pr) && mac_fail) begin
      status_next = PPAC_ST_MAC_FAIL;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= PPAC_IDLE;
      prog_cnt_reg <= 32'h0;
    end else begin
      case (state_reg)
        PPAC_IDLE: begin
          if (wr_go || pr_go) begin
            state_reg <= PPAC_WAIT_START;
          end
        end
        PPAC_WAIT_START: begin
          prog_cnt_reg <= 32'h0;
          if (prog_start) begin
            state_reg <= PPAC_PROG;
          end
        end
        PPAC_PROG: begin
          prog_cnt_reg <= prog_cnt_reg + 32'h1;
          if (prog_done) begin
            state_reg <= PPAC_IDLE;
          end
        end
        default: state_reg <= PPAC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pend_is_prot_reg <= 1'b0;
      pend_rf_reg <= 1'b0;
      pend_page_reg <= 4'h0;
      pend_block_reg <= 3'h0;
      pend_data_reg <= 32'h0;
      pend_prot_reg <= 4'h0;
    end else if (wr_go || pr_go) begin
      pend_is_prot_reg <= is_pr;
      pend_rf_reg <= cmd_from_rf;
      pend_page_reg <= cmd_page;
      pend_block_reg <= cmd_block;
      pend_data_reg <= new_word;
      pend_prot_reg <= sel_prot | cmd_prot; // RL19
    end
  end

  // array commits at the end of the self-timed cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int p = 0; p < PPAC_PAGES; p++) begin
        prot_reg[p] <= PPAC_PROT_RESET; // RL3
        for (int b = 0; b < PPAC_BLOCKS; b++) begin
          mem_reg[p][b] <= 32'h0;
        end
      end
    end else if (state_reg == PPAC_PROG && prog_done) begin
      if (pend_is_prot_reg) begin
        prot_reg[pend_page_reg] <= pend_prot_reg; // RL19
      end else begin
        mem_reg[pend_page_reg][pend_block_reg] <= pend_data_reg; // RL2
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int b = 0; b < PPAC_BLOCKS; b++) begin
        pad_reg[b] <= 32'h0;
      end
    end else if (is_pad) begin
      pad_reg[cmd_block] <= cmd_wdata; // RL12
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pend_aip_reg <= 1'b0;
      aip_cnt_reg <= 32'h0;
    end else if (aip_go) begin
      pend_aip_reg <= cmd_from_rf;
      aip_cnt_reg <= 32'h0;
    end else if (pend_aip_reg && rf_eof && aip_cnt_reg == 32'h0) begin
      aip_cnt_reg <= 32'(AIP_CYC); // RL21
      pend_aip_reg <= 1'b0;
    end else if (aip_cnt_reg != 32'h0) begin
      aip_cnt_reg <= aip_cnt_reg - 32'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      scl_cnt_reg <= 32'h0;
      i2c_stop_forced <= 1'b0;
    end else if (scl_in) begin
      scl_cnt_reg <= 32'h0;
      i2c_stop_forced <= 1'b0;
    end else begin
      // counter parks at the limit, so a long low time fires only once
      if (!scl_at_limit) begin
        scl_cnt_reg <= scl_cnt_reg + 32'h1;
      end
      i2c_stop_forced <= (scl_cnt_reg == 32'(SCL_TO_CYC - 1)); // RL17
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rsp_valid_reg <= 1'b0;
      rsp_status_reg <= PPAC_ST_OK;
      rsp_rdata_reg <= 32'h0;
      rsp_prot_reg <= 4'h0;
    end else begin
      rsp_valid_reg <= take;
      if (take) begin
        rsp_status_reg <= status_next; // RL22
        rsp_rdata_reg <= (is_rd && !rd_block) ? old_word : 32'h0; // RL4
        rsp_prot_reg <= sel_prot;
      end
    end
  end

  // word 0 occupies the low bits so bytes leave lsb first
  always_comb begin
    for (int b = 0; b < PPAC_BLOCKS; b++) begin
      hash_page_data[b*32 +: 32] = mem_reg[hash_page][b]; // RL5 RL13
      pad_data[b*32 +: 32] = pad_reg[b];
    end
  end

  assign device_serial_id = SERIAL_ID; // RL18
  assign cmd_ready = idle;
  assign busy = ~idle;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_status = rsp_status_reg;
  assign rsp_rdata = rsp_rdata_reg;
  assign rsp_prot = rsp_prot_reg;
  assign rf_access_pulse = (aip_cnt_reg != 32'h0);

  // access checks on the response side

  a_read_denied: assert property (@(posedge clk_sys) disable iff (!resetn)
    is_rd && rd_block |=> rsp_status == PPAC_ST_RD_DENIED && rsp_rdata == 32'h0) // RL4
    else $error("protected read leaked");

  a_read_data: assert property (@(posedge clk_sys) disable iff (!resetn)
    is_rd && !rd_block |=> rsp_rdata == $past(old_word)) // RL4
    else $error("open read returned wrong word");

  a_mac_fail_keep: assert property (@(posedge clk_sys) disable iff (!resetn)
    (is_wr || is_pr) && mac_fail |=> idle && rsp_status == PPAC_ST_MAC_FAIL) // RL22
    else $error("mac failure started programming");
  a_wp_no_prog: assert property (@(posedge clk_sys) disable iff (!resetn)
    is_wr && wr_block |=> idle) // RL6
    else $error("write protected page programmed");

  // programming sequence

  a_busy_refuse: assert property (@(posedge clk_sys) disable iff (!resetn)
    $past(busy) |-> !rsp_valid) // RL23
    else $error("command taken while busy");

  a_prot_sticky: assert property (@(posedge clk_sys) disable iff (!resetn)
    ($past(prot_flat) & ~prot_flat) == 64'h0) // RL19
    else $error("protection bit cleared");

  a_prog_len: assert property (@(posedge clk_sys) disable iff (!resetn)
    state_reg == PPAC_PROG |-> prog_cnt_reg < 32'(PROG_CYC)) // RL20
    else $error("programming overran");

  a_commit_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
    state_reg == PPAC_PROG && prog_done |=> idle) // RL20
    else $error("not idle after commit");

  a_and_store: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_go && and_mode |=> (pend_data_reg & ~$past(old_word)) == 32'h0) // RL7
    else $error("and mode set a bit");

  // scl timeout, access pulse and scratchpad

  a_scl_stop: assert property (@(posedge clk_sys) disable iff (!resetn)
    i2c_stop_forced |-> $past(!scl_in)) // RL17
    else $error("timeout with scl high");

  a_stop_once: assert property (@(posedge clk_sys) disable iff (!resetn)
    i2c_stop_forced |=> !i2c_stop_forced) // RL17
    else $error("forced stop repeated");

  a_pad_only: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(rf_access_pulse) |-> $past(pend_aip_reg)) // RL16
    else $error("access pulse without pad or control write");

  a_aip_bound: assert property (@(posedge clk_sys) disable iff (!resetn)
    aip_cnt_reg <= 32'(AIP_CYC)) // RL21
    else $error("access pulse too long");

  a_pad_store: assert property (@(posedge clk_sys) disable iff (!resetn)
    is_pad |=> pad_data[$past(cmd_block)*32 +: 32] == $past(cmd_wdata)) // RL12
    else $error("scratchpad word not stored");

  // main scenarios
  c_write: cover property (@(posedge clk_sys) wr_go);
  c_stop: cover property (@(posedge clk_sys) i2c_stop_forced);
  c_prot: cover property (@(posedge clk_sys) pr_go);
  c_denied: cover property (@(posedge clk_sys) is_rd && rd_block);
  c_aip: cover property (@(posedge clk_sys) $rose(rf_access_pulse));
endmodule
`default_nettype wire

/* verif/ppac_host_model.sv */
// Purpose: far side model that ends each request frame and drives scl
// Assumes: one request in flight at a time
// Notes: slow stretches the gap before the frame end
`timescale 1ns/1ps
`default_nettype none
module ppac_host_model (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic cmd_from_rf,
  input wire logic slow,
  input wire logic scl_low,
  output logic rf_eof,
  output logic i2c_last_ack,
  output logic scl_in,
  output logic pending
);
  logic [2:0] gap_reg;
  logic rf_reg;
  assign scl_in = !scl_low;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      {pending, gap_reg, rf_reg, rf_eof, i2c_last_ack} <= '0;
    end else begin
      rf_eof <= pending && gap_reg == 3'h0 && rf_reg;
      i2c_last_ack <= pending && gap_reg == 3'h0 && !rf_reg;
      if (cmd_valid && cmd_ready) begin
        pending <= 1'b1;
        gap_reg <= slow ? 3'h6 : 3'h0;
        rf_reg <= cmd_from_rf;
      end else if (gap_reg != 3'h0) gap_reg <= gap_reg - 3'h1;
      else pending <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* verif/ppac_tb.sv */
// Purpose: self-checking bench for the page protection controller
// Assumes: shortened programming, pulse and timeout counts
// Notes: a reference model predicts every response
`timescale 1ns/1ps
`default_nettype none
module ppac_tb;
  import ppac_pkg::*;
  localparam logic [63:0] SER = 64'h5A3C0F961E2D4B78; // arbitrary value
  typedef struct packed {logic [1:0] st; logic [31:0] rd; logic [3:0] pr;} ppac_exp_t;
  logic clk_sys = 0, resetn = 0, cmd_valid = 0, cmd_from_rf = 0, cmd_mac_ok = 0;
  logic slow = 0, scl_low = 0, ctrl = 0, rf_eof, i2c_last_ack, scl_in, pend;
  ppac_cmd_t cmd_op = PPAC_CMD_READ;
  logic [3:0] cmd_page = 0, cmd_prot = 0, hash_page = 0, rsp_prot;
  logic [2:0] cmd_block = 0;
  logic [31:0] cmd_wdata = 0, rsp_rdata, w;
  logic cmd_ready, rsp_valid, busy, rf_access_pulse, i2c_stop_forced;
  logic [1:0] rsp_status;
  logic [255:0] hash_page_data, pad_data;
  logic [63:0] device_serial_id;
  logic [7:0][31:0] mem_m [16] = '{default: '0};
  logic [7:0][31:0] pad_m = '0;
  logic [3:0] prot_m [16] = '{default: '0};
  ppac_exp_t exp_q [$];
  int miscompares = 0, n_tests = 0, n_ap = 0, n_stop = 0;
  always #10 clk_sys = ~clk_sys;
  ppac_core #(.PROG_CYC(20), .AIP_CYC(10), .SCL_TO_CYC(30), .SERIAL_ID(SER)) u_dut (
    .clk_sys(clk_sys), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_from_rf(cmd_from_rf), .cmd_ctrl_write(ctrl), .cmd_page(cmd_page),
    .cmd_block(cmd_block), .cmd_wdata(cmd_wdata), .cmd_prot(cmd_prot),
    .cmd_mac_ok(cmd_mac_ok), .rf_eof(rf_eof), .i2c_last_ack(i2c_last_ack), .scl_in(scl_in),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_status(rsp_status),
    .rsp_rdata(rsp_rdata), .rsp_prot(rsp_prot), .busy(busy),
    .rf_access_pulse(rf_access_pulse), .i2c_stop_forced(i2c_stop_forced),
    .hash_page(hash_page), .hash_page_data(hash_page_data), .pad_data(pad_data),
    .device_serial_id(device_serial_id));
  ppac_host_model u_host (.clk_sys(clk_sys), .resetn(resetn), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_from_rf(cmd_from_rf), .slow(slow), .scl_low(scl_low),
    .rf_eof(rf_eof), .i2c_last_ack(i2c_last_ack), .scl_in(scl_in), .pending(pend));
  task automatic chk(string nm, logic [255:0] ex, logic [255:0] got);
    n_tests++;
    if (got !== ex) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", nm, ex, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic issue(ppac_cmd_t op, logic [3:0] pg, logic [2:0] bk, logic [31:0] wd,
                       logic [3:0] pr, logic mac, logic rf);
    ppac_exp_t e;
    logic [31:0] rnd;
    int n;
    rnd = $urandom;
    e = '{PPAC_ST_OK, 32'h0, prot_m[pg]};
    if (op == PPAC_CMD_READ) begin
      if (prot_m[pg][PPAC_PROT_RD]) e.st = PPAC_ST_RD_DENIED;
      else e.rd = mem_m[pg][bk];
    end else if (op == PPAC_CMD_PAD) pad_m[bk] = wd;
    else if (prot_m[pg][PPAC_PROT_AUTH] && !mac) e.st = PPAC_ST_MAC_FAIL;
    else if (op == PPAC_CMD_PROT) prot_m[pg] = prot_m[pg] | pr;
    else if (!prot_m[pg][PPAC_PROT_WR])
      mem_m[pg][bk] = prot_m[pg][PPAC_PROT_AND] ? mem_m[pg][bk] & wd : wd;
    exp_q.push_back(e);
    @(posedge clk_sys);
    {cmd_valid, cmd_op, cmd_page, cmd_block, cmd_wdata} <= {1'b1, op, pg, bk, wd};
    {cmd_prot, cmd_mac_ok, cmd_from_rf, slow} <= {pr, mac, rf, rnd[0]};
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (n < 60 && !(cmd_ready === 1'b1 && pend === 1'b0));
    chk("done in time", 1, n < 60);
  endtask
  always @(negedge clk_sys) begin
    ppac_exp_t e;
    n_ap += (rf_access_pulse === 1'b1);
    n_stop += (i2c_stop_forced === 1'b1);
    if (rsp_valid === 1'b1) begin
      chk("pending note", 1, exp_q.size() > 0);
      if (exp_q.size() > 0) begin
        e = exp_q.pop_front();
        chk("status", e.st, rsp_status);
        chk("rdata", e.rd, rsp_rdata);
        chk("prot", e.pr, rsp_prot);
      end
    end
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h68D0));
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int p = 0; p < 16; p++) issue(PPAC_CMD_READ, p, 3'h7, 0, 0, 0, p[0]);
    for (int p = 1; p < 7; p++) begin
      w = $urandom;
      issue(PPAC_CMD_WRITE, p, 3'h2, w, 0, 0, p[0]);
    end
    issue(PPAC_CMD_PROT, 2, 0, 0, 4'h4, 0, 1);
    w = $urandom;
    issue(PPAC_CMD_WRITE, 2, 3'h2, w, 0, 0, 0);
    issue(PPAC_CMD_READ, 2, 3'h2, 0, 0, 0, 1);
    issue(PPAC_CMD_READ, 3, 3'h2, 0, 0, 0, 0);
    issue(PPAC_CMD_PROT, 4, 0, 0, 4'h6, 0, 0);
    issue(PPAC_CMD_WRITE, 4, 3'h2, 32'h0, 0, 0, 1);
    issue(PPAC_CMD_PROT, 4, 0, 0, 4'h0, 0, 1);
    issue(PPAC_CMD_READ, 4, 3'h2, 0, 0, 0, 0);
    issue(PPAC_CMD_PROT, 5, 0, 0, 4'h1, 0, 1);
    issue(PPAC_CMD_READ, 5, 3'h2, 0, 0, 0, 0);
    @(posedge clk_sys);
    hash_page <= 4'h5;
    @(negedge clk_sys);
    chk("hash page", mem_m[5], hash_page_data);
    issue(PPAC_CMD_PROT, 6, 0, 0, 4'h8, 1, 1);
    issue(PPAC_CMD_WRITE, 6, 3'h2, 32'h0, 0, 0, 1);
    issue(PPAC_CMD_PROT, 6, 0, 0, 4'h2, 0, 0);
    w = $urandom;
    issue(PPAC_CMD_WRITE, 6, 3'h2, w, 0, 1, 0);
    issue(PPAC_CMD_READ, 6, 3'h2, 0, 0, 0, 1);
    w = $urandom;
    issue(PPAC_CMD_PAD, 0, 3'h3, w, 0, 0, 1);
    repeat (15) @(negedge clk_sys);
    issue(PPAC_CMD_PAD, 0, 3'h0, ~w, 0, 0, 0);
    @(posedge clk_sys);
    ctrl <= 1'b1;
    issue(PPAC_CMD_READ, 0, 3'h1, 0, 0, 0, 1);
    @(posedge clk_sys);
    ctrl <= 1'b0;
    repeat (15) @(negedge clk_sys);
    chk("scratchpad", pad_m, pad_data);
    chk("access pulse", 20, n_ap);
    @(posedge clk_sys);
    scl_low <= 1'b1;
    repeat (35) @(posedge clk_sys);
    scl_low <= 1'b0;
    @(negedge clk_sys);
    chk("forced stop", 1, n_stop);
    chk("serial id", SER, device_serial_id);
    complete_run();
  end
endmodule
`default_nettype wire
